// File: rtl/csm_pkg.sv
package csm_pkg;
  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_DATA = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_OPER = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0C;
  localparam logic [7:0] OFF_START = 8'h10;
  localparam logic [7:0] OFF_STOP = 8'h14;
  localparam logic [7:0] OFF_OE = 8'h18;
  localparam logic [7:0] OFF_LVL = 8'h1C;
  localparam logic [7:0] OFF_PRESC = 8'h20;
  localparam logic [7:0] OFF_PCLK = 8'h24;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int MODE_ISS = 0;
  localparam int MODE_CKS = 1;
  localparam int OPER_DAP = 0;
  localparam int OPER_CKP = 1;
  localparam int OPER_LSB = 2;
  localparam int OPER_LEN8 = 3;
  localparam int STAT_TSF = 0;
  localparam int STAT_BFF = 1;
  localparam int STAT_OVF = 2;
  localparam int STAT_SE = 3;
  localparam int LVL_SDO = 0;
  localparam int LVL_SCK = 1;
  localparam int DATA_BAUD_LSB = 9;
  localparam int DATA_BAUD_MSB = 15;
  localparam int PRESC_A_LSB = 0;
  localparam int PRESC_B_LSB = 4;

  // ---------------------------------------------------------------
  // Reset values and counts
  // ---------------------------------------------------------------
  localparam logic [1:0] RST_LVL = 2'h3;
  localparam logic RST_PCLK = 1'b1;
  localparam logic [3:0] RST_OPER = 4'h8;
  localparam logic [6:0] RST_BAUD = 7'h00;
  localparam logic [4:0] HALVES_8 = 5'h10;
  localparam logic [4:0] HALVES_7 = 5'h0E;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {
    CSM_IDLE = 1'b0,
    CSM_SHIFT = 1'b1
  } csm_state_t;
endpackage

// File: rtl/csm_axil_slave.sv
`timescale 1ns/1ps
module csm_axil_slave (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // AXI4-Lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Register side
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_hit,
  output logic rd_en,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_hit
);
  logic aw_full;
  logic w_full;

  assign awready = !aw_full;
  assign wready = !w_full;
  assign wr_en = aw_full && w_full && !bvalid;
  assign arready = !rvalid;
  assign rd_en = arvalid && !rvalid;
  assign rd_addr = araddr;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= csm_pkg::RESP_OKAY;
    end
    else
    begin
      if (awvalid && !aw_full)
      begin
        aw_full <= 1'b1;
        wr_addr <= awaddr;
      end
      else if (wr_en)
        aw_full <= 1'b0;
      if (wvalid && !w_full)
      begin
        w_full <= 1'b1;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
      else if (wr_en)
        w_full <= 1'b0;
      if (wr_en)
      begin
        bvalid <= 1'b1;
        bresp <= wr_hit ? csm_pkg::RESP_OKAY : csm_pkg::RESP_SLVERR;
      end
      else if (bready)
        bvalid <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= csm_pkg::RESP_OKAY;
    end
    else if (rd_en)
    begin
      rvalid <= 1'b1;
      rdata <= rd_hit ? rd_data : 32'h0000_0000;
      rresp <= rd_hit ? csm_pkg::RESP_OKAY : csm_pkg::RESP_SLVERR;
    end
    else if (rready)
      rvalid <= 1'b0;
  end
endmodule

// File: rtl/csm_baud_gen.sv
`timescale 1ns/1ps
module csm_baud_gen #(
  parameter bit FAST_CHANNEL = 1'b1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Setup
  input wire logic [3:0] presc_a,
  input wire logic [3:0] presc_b,
  input wire logic clk_sel,
  input wire logic [6:0] baud,
  input wire logic run,
  // Half serial period strobe
  output logic half_tick
);
  logic [14:0] pre;
  logic [6:0] cnt;
  wire logic [3:0] k_sel;
  wire logic [14:0] mask;
  wire logic op_tick;
  wire logic [6:0] limit;

  // Second prescaler output chosen by the select bit
  assign k_sel = clk_sel ? presc_b : presc_a; // RULE25
  assign mask = 15'((16'h0001 << k_sel) - 16'h0001);
  assign op_tick = (pre & mask) == mask;
  // Slow channels cannot reach one system clock per half period
  assign limit = (!FAST_CHANNEL && k_sel == 4'h0 && baud == 7'h00) ? 7'h01 : baud; // RULE7
  assign half_tick = run && op_tick && cnt == limit; // RULE17

  always_ff @(posedge sys_clk)
  begin
    if (rst || !run)
      pre <= 15'h0000;
    else
      pre <= pre + 15'h0001;
  end

  // Divider restarts with each word so the first half period is whole
  always_ff @(posedge sys_clk)
  begin
    if (rst || !run)
      cnt <= 7'h00;
    else if (op_tick)
      cnt <= (cnt == limit) ? 7'h00 : cnt + 7'h01;
  end
endmodule

// File: rtl/csm_channel.sv
`timescale 1ns/1ps
// How it works
// RULE1: Interrupt source bit may be rewritten mid-transfer without disturbing it.
// RULE2: Software flips interrupt source before the final word's last bit.
// RULE3: Master drives serial clock, shifts data out and samples data in together.
// RULE4: Interrupt fires at transfer end or when transmit buffer empties.
// RULE5: Only receive overrun is detected; no framing or parity checks.
// RULE6: Word length is selectable as 7 or 8 bits.
// RULE7: Fastest clock is system clock/2 here, /4 elsewhere; slowest 2*2^15*128.
// RULE8: Data phase bit set shifts data half a clock before clock starts.
// RULE9: Clock polarity bit selects normal or inverted serial clock.
// RULE10: Bit order is selectable, MSB first or LSB first.
// RULE11: Software waits for transfer-active clear before stopping, unless urgent.
// RULE12: Writing 1 to stop trigger clears channel-enabled status.
// RULE13: Output-enable cleared stops channel driving clock and data pins.
// RULE14: Removing peripheral clock enable resets the whole unit.
// RULE15: Software waits for slave to stop before resuming.
// RULE16: Software disables port pins around reconfiguration before restart.
// RULE17: Upper data register field divides operation clock for baud rate.
// RULE18: With outputs disabled, output level register sets pin idle levels.
// RULE19: Output-enable set lets channel drive clock and data pins.
// RULE20: Writing 1 to start trigger sets channel-enabled; zeros do nothing.
// RULE21: Writing data low byte while enabled starts a transfer.
// RULE22: Writing data while buffer full overwrites the buffered word.
// RULE23: Interrupt source 0 means transfer end, 1 means buffer empty.
// RULE24: Receive-only software writes all-ones dummy data per word.
// RULE25: Operation clock picks prescaler clock a (0) or b (1).
// RULE26: Overrun sets when a word completes before the last was read.
// RULE27: Transfer-active is one from transfer start until the last bit shifted.
module csm_channel #(
  parameter bit FAST_CHANNEL = 1'b1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // AXI4-Lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Serial link
  output logic sck_out,
  output logic sdo_out,
  input wire logic sdi_in,
  // Channel interrupt
  output logic irq
);
  // ---------------------------------------------------------------
  // Registers and state
  // ---------------------------------------------------------------
  logic per_en;
  logic chan_en;
  logic oe;
  logic [1:0] lvl;
  logic md;
  logic cks;
  logic [3:0] oper;
  logic [6:0] baud;
  logic [7:0] presc;
  logic [7:0] txbuf;
  logic bff;
  logic [7:0] rxbuf;
  logic rx_unread;
  logic ovf;
  logic [7:0] txw;
  logic [7:0] rxw;
  logic [4:0] hh;
  csm_pkg::csm_state_t state;

  wire logic unit_rst;
  wire logic wr_en;
  wire logic [7:0] wr_addr;
  wire logic [31:0] wr_data;
  wire logic [3:0] wr_strb;
  wire logic rd_en;
  wire logic [7:0] rd_addr;
  wire logic [31:0] rd_data;
  wire logic wr_hit;
  wire logic rd_hit;
  wire logic half_tick;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = a == off;
  endfunction

  function automatic logic hit_any(input logic [7:0] a);
    hit_any = hit(a, csm_pkg::OFF_DATA) || hit(a, csm_pkg::OFF_MODE)
      || hit(a, csm_pkg::OFF_OPER) || hit(a, csm_pkg::OFF_STAT)
      || hit(a, csm_pkg::OFF_START) || hit(a, csm_pkg::OFF_STOP)
      || hit(a, csm_pkg::OFF_OE) || hit(a, csm_pkg::OFF_LVL)
      || hit(a, csm_pkg::OFF_PRESC) || hit(a, csm_pkg::OFF_PCLK);
  endfunction

  // Physical bit slot for the i-th bit on the wire
  function automatic logic [2:0] slot(input logic [2:0] i, input logic lsb, input logic len8);
    slot = lsb ? i : (len8 ? 3'h7 - i : 3'h6 - i);
  endfunction

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  csm_axil_slave u_bus (
    .sys_clk(sys_clk),
    .rst(rst),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_hit(wr_hit),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_hit(rd_hit)
  );

  assign wr_hit = hit_any(wr_addr);
  assign rd_hit = hit_any(rd_addr);

  // Whole unit except the bus slave and per_en held in reset while its clock supply is off
  assign unit_rst = rst || !per_en; // RULE14

  wire logic wr_b0 = wr_en && wr_strb[0];
  wire logic wr_data_lo = wr_b0 && hit(wr_addr, csm_pkg::OFF_DATA);
  wire logic wr_data_hi = wr_en && wr_strb[1] && hit(wr_addr, csm_pkg::OFF_DATA);
  wire logic wr_mode = wr_b0 && hit(wr_addr, csm_pkg::OFF_MODE);
  wire logic wr_oper = wr_b0 && hit(wr_addr, csm_pkg::OFF_OPER);
  wire logic wr_stat = wr_b0 && hit(wr_addr, csm_pkg::OFF_STAT);
  wire logic wr_oe = wr_b0 && hit(wr_addr, csm_pkg::OFF_OE);
  wire logic wr_lvl = wr_b0 && hit(wr_addr, csm_pkg::OFF_LVL);
  wire logic wr_presc = wr_b0 && hit(wr_addr, csm_pkg::OFF_PRESC);
  wire logic wr_pclk = wr_b0 && hit(wr_addr, csm_pkg::OFF_PCLK);
  wire logic start_wr = wr_b0 && hit(wr_addr, csm_pkg::OFF_START) && wr_data[0]; // RULE20
  wire logic stop_wr = wr_b0 && hit(wr_addr, csm_pkg::OFF_STOP) && wr_data[0]; // RULE12
  wire logic rd_data_reg = rd_en && hit(rd_addr, csm_pkg::OFF_DATA);

  wire logic dap = oper[csm_pkg::OPER_DAP];
  wire logic ckp = oper[csm_pkg::OPER_CKP];
  wire logic lsb = oper[csm_pkg::OPER_LSB];
  wire logic len8 = oper[csm_pkg::OPER_LEN8];
  wire logic tsf = state == csm_pkg::CSM_SHIFT; // RULE27
  wire logic [4:0] last_half = (len8 ? csm_pkg::HALVES_8 : csm_pkg::HALVES_7) - {4'h0, !dap};

  // ---------------------------------------------------------------
  // Engine decode
  // ---------------------------------------------------------------
  wire logic load = !tsf && chan_en && bff && !stop_wr; // RULE21
  wire logic done = tsf && half_tick && hh == last_half;
  // Sample on entering an odd half: rising edge for normal phase
  wire logic sample = tsf && half_tick && !hh[0] && !done; // RULE3
  wire logic lead = dap && hh == 5'h00; // RULE8
  wire logic phase_hi = lead ? 1'b1 : (hh[0] ^ dap);
  wire logic sck_eng = tsf ? phase_hi ^ ckp : lvl[csm_pkg::LVL_SCK]; // RULE9
  wire logic sdo_eng = tsf ? txw[slot(hh[3:1], lsb, len8)] : lvl[csm_pkg::LVL_SDO]; // RULE10
  wire logic next_sck = oe ? sck_eng : lvl[csm_pkg::LVL_SCK]; // RULE13 RULE18 RULE19
  wire logic next_sdo = oe ? sdo_eng : lvl[csm_pkg::LVL_SDO];
  wire logic next_irq = md ? load : done; // RULE4 RULE23
  // Overrun is the only error source; set wins over the clear
  wire logic next_ovf = (done && rx_unread && !rd_data_reg)
    || (ovf && !(wr_stat && wr_data[csm_pkg::STAT_OVF])); // RULE5 RULE26

  assign rd_data =
    hit(rd_addr, csm_pkg::OFF_DATA) ? {16'h0000, baud, 1'b0, rxbuf} :
    hit(rd_addr, csm_pkg::OFF_MODE) ? {30'h0, cks, md} :
    hit(rd_addr, csm_pkg::OFF_OPER) ? {28'h0, oper} :
    hit(rd_addr, csm_pkg::OFF_STAT) ? {28'h0, chan_en, ovf, bff, tsf} :
    hit(rd_addr, csm_pkg::OFF_OE) ? {31'h0, oe} :
    hit(rd_addr, csm_pkg::OFF_LVL) ? {30'h0, lvl} :
    hit(rd_addr, csm_pkg::OFF_PRESC) ? {24'h0, presc} :
    hit(rd_addr, csm_pkg::OFF_PCLK) ? {31'h0, per_en} : 32'h0000_0000;

  csm_baud_gen #(
    .FAST_CHANNEL(FAST_CHANNEL)
  ) u_baud (
    .sys_clk(sys_clk),
    .rst(unit_rst),
    .presc_a(presc[csm_pkg::PRESC_A_LSB +: 4]),
    .presc_b(presc[csm_pkg::PRESC_B_LSB +: 4]),
    .clk_sel(cks),
    .baud(baud),
    .run(tsf),
    .half_tick(half_tick)
  );

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      per_en <= csm_pkg::RST_PCLK;
    else if (wr_pclk)
      per_en <= wr_data[0];
  end

  always_ff @(posedge sys_clk)
  begin
    if (unit_rst)
    begin
      md <= 1'b0;
      cks <= 1'b0;
      oper <= csm_pkg::RST_OPER;
      baud <= csm_pkg::RST_BAUD;
      presc <= 8'h00;
      oe <= 1'b0;
      lvl <= csm_pkg::RST_LVL;
    end
    else
    begin
      if (wr_mode)
      begin
        md <= wr_data[csm_pkg::MODE_ISS]; // RULE1
        cks <= wr_data[csm_pkg::MODE_CKS];
      end
      if (wr_oper)
        oper <= wr_data[3:0]; // RULE6
      if (wr_data_hi)
        baud <= wr_data[csm_pkg::DATA_BAUD_MSB:csm_pkg::DATA_BAUD_LSB]; // RULE17
      if (wr_presc)
        presc <= wr_data[7:0];
      if (wr_oe)
        oe <= wr_data[0];
      if (wr_lvl)
        lvl <= wr_data[1:0];
    end
  end

  // ---------------------------------------------------------------
  // Channel status and buffers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (unit_rst)
    begin
      chan_en <= 1'b0;
      txbuf <= 8'h00;
      bff <= 1'b0;
      rxbuf <= 8'h00;
      rx_unread <= 1'b0;
      ovf <= 1'b0;
      irq <= 1'b0;
      sck_out <= csm_pkg::RST_LVL[csm_pkg::LVL_SCK];
      sdo_out <= csm_pkg::RST_LVL[csm_pkg::LVL_SDO];
    end
    else
    begin
      if (stop_wr)
        chan_en <= 1'b0;
      else if (start_wr)
        chan_en <= 1'b1;
      if (wr_data_lo && chan_en)
        txbuf <= wr_data[7:0]; // RULE22
      bff <= (wr_data_lo && chan_en) || (bff && !load);
      if (done)
        rxbuf <= len8 ? rxw : {1'b0, rxw[6:0]};
      rx_unread <= done || (rx_unread && !rd_data_reg);
      ovf <= next_ovf;
      irq <= next_irq;
      sck_out <= next_sck;
      sdo_out <= next_sdo;
    end
  end

  // ---------------------------------------------------------------
  // Shift engine
  // ---------------------------------------------------------------
  // An urgent stop abandons the word at once
  always_ff @(posedge sys_clk)
  begin
    if (unit_rst || stop_wr)
    begin
      state <= csm_pkg::CSM_IDLE;
      hh <= 5'h00;
    end
    else if (load)
    begin
      state <= csm_pkg::CSM_SHIFT;
      hh <= 5'h00;
    end
    else if (done)
      state <= csm_pkg::CSM_IDLE;
    else if (tsf && half_tick)
      hh <= hh + 5'h01;
  end

  always_ff @(posedge sys_clk)
  begin
    if (unit_rst)
    begin
      txw <= 8'h00;
      rxw <= 8'h00;
    end
    else if (load)
    begin
      txw <= txbuf;
      rxw <= 8'h00;
    end
    else if (sample)
      rxw[slot(hh[3:1], lsb, len8)] <= sdi_in; // RULE3 RULE10
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_start_sets_enable: assert property (@(posedge sys_clk) disable iff (unit_rst)
    start_wr && !stop_wr |=> chan_en) else $error("start did not enable"); // RULE20
  a_stop_halts_channel: assert property (@(posedge sys_clk) disable iff (unit_rst)
    stop_wr |=> !chan_en && !tsf) else $error("stop did not halt"); // RULE12
  a_pins_idle_level: assert property (@(posedge sys_clk) disable iff (unit_rst)
    !oe && !$past(wr_lvl) |=> sck_out == $past(lvl[1]) && sdo_out == $past(lvl[0]))
    else $error("idle levels not driven"); // RULE13
  a_write_fills_buf: assert property (@(posedge sys_clk) disable iff (unit_rst)
    wr_data_lo && chan_en |=> bff) else $error("data write lost"); // RULE21
  a_active_until_done: assert property (@(posedge sys_clk) disable iff (unit_rst)
    tsf && !done && !stop_wr |=> tsf) else $error("transfer ended early"); // RULE27
  a_irq_source_sel: assert property (@(posedge sys_clk) disable iff (unit_rst)
    irq |-> ($past(md) && $past(load)) || (!$past(md) && $past(done)))
    else $error("interrupt from wrong event"); // RULE4
  a_overrun_on_unread: assert property (@(posedge sys_clk) disable iff (unit_rst)
    done && rx_unread && !rd_data_reg |=> ovf) else $error("overrun missed"); // RULE26
  a_slow_rate_limit: assert property (@(posedge sys_clk) disable iff (unit_rst)
    !FAST_CHANNEL && half_tick |=> !half_tick) else $error("clock too fast"); // RULE7
  a_mode_write_safe: assert property (@(posedge sys_clk) disable iff (unit_rst)
    wr_mode && tsf && !done && !stop_wr |=> tsf && hh == $past(hh) + 5'($past(half_tick)))
    else $error("mode write disturbed transfer"); // RULE1
endmodule

// File: sim/csm_slave_model.sv
`timescale 1ns/1ps
module csm_slave_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Serial link
  input wire logic sck,
  input wire logic sdo,
  output logic sdi,
  // Bench control
  input wire logic samp_rise,
  input wire logic load,
  input wire logic [7:0] load_word,
  output logic [7:0] rx_word,
  output logic [7:0] bit_cnt
);
  // --------------------------------
  // Shift logic
  // --------------------------------
  logic sck_q;
  logic [7:0] tx_word;

  // Master samples a cycle before its pin edge, so shifting here is safe
  always_ff @(posedge sys_clk)
  begin
    sck_q <= sck;
    if (rst || load)
    begin
      tx_word <= load_word;
      rx_word <= 8'h00;
      bit_cnt <= 8'h00;
    end
    else if (sck !== sck_q && sck === samp_rise)
    begin
      rx_word <= {rx_word[6:0], sdo};
      tx_word <= {tx_word[6:0], ~tx_word[7]};
      bit_cnt <= bit_cnt + 8'h01;
    end
  end

  // Toggling fill keeps a stale level from looking valid between frames
  assign sdi = tx_word[7];
endmodule

// File: sim/csm_channel_tb.sv
`timescale 1ns/1ps
module csm_channel_tb;
  // --------------------------------
  // Harness
  // --------------------------------
  logic sys_clk, rst, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic arready, rvalid, sck_out, sdo_out, sdi_in, irq, samp_rise, sl_load;
  logic [7:0] awaddr, araddr, sl_word, sl_rx, sl_cnt;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [3:0] cfgs [4] = '{4'h8, 4'hF, 4'h6, 4'h1};
  int fail_count, checked, irq_cnt, s0;

  csm_channel #(.FAST_CHANNEL(1'b1)) i_dut (
    .sys_clk(sys_clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .sck_out(sck_out),
    .sdo_out(sdo_out), .sdi_in(sdi_in), .irq(irq));

  csm_slave_model i_slave (.sys_clk(sys_clk), .rst(rst), .sck(sck_out), .sdo(sdo_out),
    .sdi(sdi_in), .samp_rise(samp_rise), .load(sl_load), .load_word(sl_word),
    .rx_word(sl_rx), .bit_cnt(sl_cnt));

  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 300);
    chk({bvalid, bresp}, {1'b1, er});
  endtask

  task automatic rdr(input logic [7:0] a, input logic [1:0] er = 2'h0);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 300);
    rd = rdata;
    chk({rvalid, rresp}, {1'b1, er});
  endtask

  task automatic sl_ld(input logic rise, input logic [7:0] s);
    samp_rise <= rise;
    sl_word <= s;
    sl_load <= 1'b1;
    @(posedge sys_clk);
    sl_load <= 1'b0;
  endtask

  task automatic wait_irq();
    int s, n;
    s = irq_cnt;
    n = 0;
    while (irq_cnt == s && n < 3000)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk(32'(irq_cnt > s), 32'h1);
  endtask

  task automatic half_per(input int exp);
    int n;
    logic l;
    for (int k = 0; k < 2; k++)
    begin
      l = sck_out;
      n = 0;
      while (sck_out === l && n < 500)
      begin
        @(posedge sys_clk);
        n++;
      end
    end
    chk(n, exp);
  endtask

  function automatic logic [7:0] order(input logic [7:0] v, input int len, input logic lsb);
    logic [7:0] o;
    o = 8'h00;
    for (int i = 0; i < len; i++) o[i] = lsb ? v[len-1-i] : v[i];
    return o;
  endfunction

  function automatic logic [31:0] dw(input logic [6:0] b, input logic [7:0] d);
    return {16'h0000, b, 1'b0, d};
  endfunction

  // Config bits: 0 data phase, 1 clock polarity, 2 LSB first, 3 eight bits
  task automatic xfer(input logic [3:0] c, input logic [7:0] d, input logic [7:0] s);
    int len;
    len = c[3] ? 8 : 7;
    wr(csm_pkg::OFF_OE, 32'h0);
    wr(csm_pkg::OFF_OPER, {28'h0, c});
    wr(csm_pkg::OFF_LVL, {30'h0, ~c[1], 1'b1});
    wr(csm_pkg::OFF_OE, 32'h1);
    sl_ld(c[0] == c[1], s);
    wr(csm_pkg::OFF_DATA, dw(7'h01, d));
    rdr(csm_pkg::OFF_STAT);
    chk(rd, 32'h9);
    wait_irq();
    chk(order(sl_rx, len, 1'b0), order(d, len, c[2]));
    rdr(csm_pkg::OFF_DATA);
    chk(rd[7:0], order(s >> (8 - len), len, c[2]));
    rdr(csm_pkg::OFF_STAT);
    chk(rd, 32'h8);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // --------------------------------
  // Tests
  // --------------------------------
  initial
  begin
    {rst, awvalid, wvalid, bready, arvalid, rready, samp_rise, sl_load} = 8'h80;
    {awaddr, araddr, sl_word, wdata, wstrb} = {24'h0, 32'h0, 4'hF};
    {fail_count, checked, irq_cnt} = '0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rdr(csm_pkg::OFF_OPER);
    chk(rd, 32'h8);
    chk({sck_out, sdo_out}, 32'h3);
    rdr(8'h28, csm_pkg::RESP_SLVERR);
    wr(8'h28, 32'hFF, csm_pkg::RESP_SLVERR);
    wr(csm_pkg::OFF_LVL, 32'h0);
    repeat (3) @(posedge sys_clk);
    chk({sck_out, sdo_out}, 32'h0);
    wr(csm_pkg::OFF_START, 32'h0);
    rdr(csm_pkg::OFF_STAT);
    chk(rd, 32'h0);
    wr(csm_pkg::OFF_START, 32'h1);
    rdr(csm_pkg::OFF_STAT);
    chk(rd, 32'h8);
    $display("test reset done");
    for (int i = 0; i < 4; i++) xfer(cfgs[i], 8'hB4 + 8'(i * 37), 8'h5C + 8'(i * 91));
    xfer(4'h8, 8'hFF, 8'h3A);
    $display("test frames done");
    wr(csm_pkg::OFF_DATA, dw(7'h01, 8'h11));
    wait_irq();
    wr(csm_pkg::OFF_DATA, dw(7'h01, 8'h22));
    wait_irq();
    rdr(csm_pkg::OFF_STAT);
    chk(rd, 32'hC);
    wr(csm_pkg::OFF_STAT, 32'h4);
    rdr(csm_pkg::OFF_STAT);
    chk(rd, 32'h8);
    rdr(csm_pkg::OFF_DATA);
    $display("test overrun done");
    wr(csm_pkg::OFF_MODE, 32'h1);
    sl_ld(1'b1, 8'h00);
    s0 = irq_cnt;
    wr(csm_pkg::OFF_DATA, dw(7'h01, 8'h81));
    wr(csm_pkg::OFF_DATA, dw(7'h01, 8'h42));
    rdr(csm_pkg::OFF_STAT);
    chk(rd, 32'hB);
    wr(csm_pkg::OFF_DATA, dw(7'h01, 8'h3C));
    wr(csm_pkg::OFF_MODE, 32'h0);
    do rdr(csm_pkg::OFF_STAT); while (rd[1:0] !== 2'b00 && checked < 5000);
    chk(sl_cnt, 32'h10);
    chk(sl_rx, 32'h3C);
    chk(irq_cnt - s0, 32'h3);
    rdr(csm_pkg::OFF_DATA);
    wr(csm_pkg::OFF_STAT, 32'h4);
    $display("test continuous done");
    wr(csm_pkg::OFF_DATA, dw(7'h01, 8'h99));
    wr(csm_pkg::OFF_STOP, 32'h1);
    rdr(csm_pkg::OFF_STAT);
    chk(rd, 32'h0);
    wr(csm_pkg::OFF_DATA, dw(7'h01, 8'h66));
    rdr(csm_pkg::OFF_STAT);
    chk(rd, 32'h0);
    wr(csm_pkg::OFF_OE, 32'h0);
    wr(csm_pkg::OFF_LVL, 32'h2);
    repeat (3) @(posedge sys_clk);
    chk({sck_out, sdo_out}, 32'h2);
    $display("test stop done");
    wr(csm_pkg::OFF_PCLK, 32'h0);
    wr(csm_pkg::OFF_OPER, 32'h0);
    rdr(csm_pkg::OFF_OPER);
    chk(rd, 32'h8);
    chk({sck_out, sdo_out}, 32'h3);
    wr(csm_pkg::OFF_PCLK, 32'h1);
    $display("test unit reset done");
    wr(csm_pkg::OFF_START, 32'h1);
    wr(csm_pkg::OFF_OE, 32'h1);
    wr(csm_pkg::OFF_PRESC, 32'h21);
    sl_ld(1'b1, 8'h00);
    wr(csm_pkg::OFF_DATA, dw(7'h02, 8'h5A));
    half_per(6);
    wait_irq();
    wr(csm_pkg::OFF_MODE, 32'h2);
    wr(csm_pkg::OFF_DATA, dw(7'h00, 8'hA5));
    half_per(4);
    wait_irq();
    $display("test baud done");
    summarize();
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    $display("BAD t=%0t watchdog expired", $time);
    summarize();
  end
endmodule
